// *** dmr_mode_decode.sv ***
// mode-word and extended-mode-word decode with the behaviour they steer
// assumes command pins sampled on mclk and a register master on the plain port
`timescale 1ns/100ps
module dmr_mode_decode
  import dmr_pkg::*;
#(
  parameter int FAST_EXIT_CYCLES = FAST_EXIT_DEF,
  parameter int SLOW_EXIT_CYCLES = SLOW_EXIT_DEF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // command pins from the memory controller
  input  wire dmr_cmd_t    cmd,
  input  wire logic        cke,
  input  wire logic        odt,
  // register port
  input  wire logic [1:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // decoded controls
  output logic             dllEnable,
  output logic             dllResetPulse,
  output logic             dllFrozen,
  output logic             readReady,
  output logic             testMode,
  output logic             readFirstData,
  output logic             prechargePulse,
  output logic      [2:0]  prechargeBank,
  output logic             driveReduced,
  output logic      [1:0]  rttCode,
  output logic             termOn,
  output dmr_oe_t          outEnables
);
  if (FAST_EXIT_CYCLES < 1 || FAST_EXIT_CYCLES > 15 ||
      SLOW_EXIT_CYCLES < 1 || SLOW_EXIT_CYCLES > 15) begin : g_bad_exit
    $error("exit delay counts must lie in 1..15");
  end

  localparam logic [3:0] FAST_EXIT = 4'(FAST_EXIT_CYCLES);
  localparam logic [3:0] SLOW_EXIT = 4'(SLOW_EXIT_CYCLES);

  logic [1:0] rstSync;
  logic       rstLocalN;
  dmr_state_t st;
  dmr_state_t next_st;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstLocalN = rstSync[1];

  // command decode, only while the clock is enabled except self refresh entry
  logic cmdSel;
  logic isLoad;
  logic isRefresh;
  logic isAct;
  logic isPre;
  logic isRead;
  logic isWrite;
  logic modeLoad;
  logic extLoad;
  assign cmdSel    = !cmd.csN;
  assign isLoad    = cmdSel && !cmd.rasN && !cmd.casN && !cmd.weN && cke;
  assign isRefresh = cmdSel && !cmd.rasN && !cmd.casN && cmd.weN;
  assign isAct     = cmdSel && !cmd.rasN && cmd.casN && cmd.weN && cke;
  assign isPre     = cmdSel && !cmd.rasN && cmd.casN && !cmd.weN && cke;
  assign isRead    = cmdSel && cmd.rasN && !cmd.casN && cmd.weN && cke;
  assign isWrite   = cmdSel && cmd.rasN && !cmd.casN && !cmd.weN && cke;
  assign modeLoad  = isLoad && (cmd.ba[1:0] == BA_MODE);
  assign extLoad   = isLoad && (cmd.ba[1:0] == BA_EXT);

  // latencies from the stored words; reserved codes fall back to the nearest legal one
  logic [2:0] clCode;
  logic [2:0] alCode;
  logic [2:0] wrCode;
  logic [2:0] clVal;
  logic [2:0] alVal;
  logic [3:0] wrVal;
  logic [2:0] blClocks;
  logic [3:0] readLat;
  logic [3:0] writeLat;
  logic [4:0] apTotal;
  logic [1:0] newRtt;
  assign clCode   = st.modeWord[MR_CL_LSB +: 3];
  assign alCode   = st.extWord[EMR_AL_LSB +: 3];
  assign wrCode   = st.modeWord[MR_WR_LSB +: 3];
  assign clVal    = (clCode < CL_MIN) ? CL_MIN : clCode; // [RULE9]
  assign alVal    = (alCode > AL_MAX) ? AL_MAX : alCode; // [RULE25]
  assign wrVal    = (wrCode == 3'h0) ? WR_MIN : ({1'b0, wrCode} + 4'h1);
  assign blClocks = (st.modeWord[MR_BL_LSB +: 3] == BL8_CODE) ? BL8_CLOCKS : BL4_CLOCKS;
  // whole-clock sums only, there is no half-clock path
  assign readLat  = {1'b0, clVal} + {1'b0, alVal}; // [RULE10] [RULE25]
  assign writeLat = readLat - 4'h1; // [RULE25]
  assign apTotal  = {1'b0, writeLat} + {2'h0, blClocks} + {1'b0, wrVal}; // [RULE4]
  assign newRtt   = {cmd.addr[EMR_RTT_HI_BIT], cmd.addr[EMR_RTT_LO_BIT]};

  always_comb begin
    logic [2:0] errSet;
    logic       readBurst;
    logic       outsOn;
    errSet  = 3'h0;
    readBurst = 1'b0;
    outsOn    = 1'b0;
    next_st = st;
    next_st.dllResetPulse = 1'b0;
    next_st.precPulse     = 1'b0;
    next_st.rdPipe        = {1'b0, st.rdPipe[15:1]};
    if (st.burstCnt != 3'h0) begin
      next_st.burstCnt = st.burstCnt - 3'h1;
    end
    if (st.rdPipe[1]) begin
      next_st.burstCnt = blClocks;
    end
    if (st.dllLockCnt != 8'h00) begin
      next_st.dllLockCnt = st.dllLockCnt - 8'h01;
    end
    if (st.exitCnt != 4'h0) begin
      next_st.exitCnt = st.exitCnt - 4'h1;
    end
    if (st.odtHoldCnt != 4'h0) begin
      next_st.odtHoldCnt = st.odtHoldCnt - 4'h1;
    end
    if (st.apCnt != 5'h00) begin
      next_st.apCnt = st.apCnt - 5'h01;
      if (st.apCnt == 5'h01) begin
        next_st.precPulse = 1'b1; // [RULE4]
        next_st.precBank  = st.apBank;
        next_st.bankOpen[st.apBank] = 1'b0;
      end
    end
    // mode word load
    if (modeLoad) begin
      if (cmd.addr[MR_TEST_BIT]) begin
        next_st.testMode = 1'b1; // [RULE1]
        next_st.modeWord[MR_TEST_BIT] = 1'b1;
      end else begin
        next_st.testMode = 1'b0;
        next_st.modeWord = cmd.addr; // [RULE1]
        next_st.modeWord[MR_DLL_RST_BIT] = 1'b0; // [RULE2]
        if (cmd.addr[MR_DLL_RST_BIT]) begin
          next_st.dllResetPulse = 1'b1; // [RULE2]
          next_st.dllLockCnt    = DLL_LOCK_CYCLES; // [RULE3]
          next_st.dllNeedsReset = 1'b0; // [RULE14]
        end
        if (cmd.addr[MR_CL_LSB +: 3] < CL_MIN || cmd.addr[MR_WR_LSB +: 3] == 3'h0) begin
          errSet[ERR_RESERVED] = 1'b1; // [RULE5] [RULE9]
        end
      end
    end
    // extended word load, held until the next one
    if (extLoad) begin
      next_st.extWord = cmd.addr; // [RULE12]
      if (st.extWord[EMR_DLL_DIS_BIT] && !cmd.addr[EMR_DLL_DIS_BIT]) begin
        next_st.dllNeedsReset = 1'b1; // [RULE14]
      end
      if (newRtt != RTT_OFF) begin
        next_st.odtHoldCnt = ODT_HOLD_CYCLES; // [RULE23]
      end
      if (cmd.addr[EMR_AL_LSB +: 3] > AL_MAX) begin
        errSet[ERR_RESERVED] = 1'b1; // [RULE25]
      end
    end
    // bank tracking, needed to tell active from precharge power-down
    if (isAct) begin
      next_st.bankOpen[cmd.ba] = 1'b1;
    end
    if (isPre) begin
      if (cmd.addr[AP_ADDR_BIT]) begin
        next_st.bankOpen = 8'h00;
      end else begin
        next_st.bankOpen[cmd.ba] = 1'b0;
      end
    end
    // read latency pipe; one outstanding auto precharge write at a time
    if (isRead) begin
      next_st.rdPipe[readLat - 4'h1] = 1'b1; // [RULE11] [RULE25]
      if (!st.readReady) begin
        errSet[ERR_READ_EARLY] = 1'b1; // [RULE3]
      end
      if (cmd.addr[AP_ADDR_BIT]) begin
        next_st.bankOpen[cmd.ba] = 1'b0;
      end
    end
    if (isWrite && cmd.addr[AP_ADDR_BIT]) begin
      next_st.apCnt  = apTotal - 5'h01; // [RULE4]
      next_st.apBank = cmd.ba;
    end
    // power-down and self refresh
    if (!st.selfRefresh && !st.powerDown) begin
      if (isRefresh && !cke) begin
        next_st.selfRefresh = 1'b1; // [RULE15]
      end else if (!cke) begin
        next_st.powerDown = 1'b1;
        next_st.activePd  = |st.bankOpen; // [RULE8]
      end
    end else if (cke && st.selfRefresh) begin
      next_st.selfRefresh   = 1'b0;
      next_st.dllResetPulse = 1'b1; // [RULE15]
      next_st.dllLockCnt    = DLL_LOCK_CYCLES; // [RULE3]
    end else if (cke && st.powerDown) begin
      next_st.powerDown = 1'b0;
      next_st.activePd  = 1'b0;
      // precharge power-down always exits on the short count
      if (st.activePd && st.modeWord[MR_PD_BIT]) begin
        next_st.exitCnt = SLOW_EXIT; // [RULE7]
      end else begin
        next_st.exitCnt = FAST_EXIT; // [RULE6] [RULE8]
      end
    end
    if (odt && st.odtHoldCnt != 4'h0) begin
      errSet[ERR_ODT_EARLY] = 1'b1; // [RULE23]
    end
    // register port
    if (regWr && regAddr == OFS_CTRL) begin
      next_st.x8Config = regWdata[CTRL_X8_BIT];
      if (regWdata[CTRL_CLR_BIT]) begin
        next_st.errors = 3'h0;
      end
    end
    // a new error beats a clear in the same cycle
    next_st.errors = next_st.errors | errSet;
    next_st.rdata  = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        OFS_MODE:   next_st.rdata = {2'h0, st.modeWord}; // [RULE2]
        OFS_EXT:    next_st.rdata = {2'h0, st.extWord};
        OFS_STATUS: next_st.rdata = {4'h0, st.errors, st.dllNeedsReset, st.readReady,
                                     st.selfRefresh, st.powerDown, st.activePd, st.testMode,
                                     st.termOn, st.dllEnable, st.dllFrozen};
        OFS_CTRL:   next_st.rdata = {15'h0000, st.x8Config};
      endcase
    end
    // derived outputs, registered so each leaves straight from a flop
    next_st.dllEnable = !next_st.extWord[EMR_DLL_DIS_BIT] && !next_st.selfRefresh; // [RULE14] [RULE15]
    next_st.dllFrozen = next_st.powerDown && next_st.activePd &&
                        next_st.modeWord[MR_PD_BIT]; // [RULE6] [RULE7] [RULE8]
    next_st.readReady = (next_st.dllLockCnt == 8'h00) && (next_st.exitCnt == 4'h0) &&
                        !next_st.selfRefresh && !next_st.powerDown;
    next_st.termOn    = odt && !next_st.selfRefresh && (next_st.odtHoldCnt == 4'h0) &&
                        ({next_st.extWord[EMR_RTT_HI_BIT], next_st.extWord[EMR_RTT_LO_BIT]}
                         != RTT_OFF); // [RULE22] [RULE23]
    readBurst = (next_st.burstCnt != 3'h0);
    outsOn    = !next_st.extWord[EMR_OUT_DIS];
    next_st.oe.dqOe    = outsOn && readBurst; // [RULE20]
    next_st.oe.dqsOe   = outsOn && readBurst; // [RULE20]
    next_st.oe.dqsnOe  = outsOn && readBurst && !next_st.extWord[EMR_DQSN_DIS]; // [RULE18]
    // the strobe copy is read-only; writes never sample it
    next_st.oe.rdqsOe  = outsOn && readBurst && next_st.extWord[EMR_RDQS_EN] &&
                         next_st.x8Config; // [RULE19]
    next_st.oe.rdqsnOe = next_st.oe.rdqsOe && !next_st.extWord[EMR_DQSN_DIS]; // [RULE18]
  end

  always_ff @(posedge mclk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      st          <= '0;
      st.modeWord <= MODE_RESET;
      st.extWord  <= EXT_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata       = st.rdata;
  assign dllEnable      = st.dllEnable;
  assign dllResetPulse  = st.dllResetPulse;
  assign dllFrozen      = st.dllFrozen;
  assign readReady      = st.readReady;
  assign testMode       = st.testMode;
  assign readFirstData  = st.rdPipe[0];
  assign prechargePulse = st.precPulse;
  assign prechargeBank  = st.precBank;
  assign driveReduced   = st.extWord[EMR_DRIVE_BIT]; // [RULE17]
  assign rttCode        = {st.extWord[EMR_RTT_HI_BIT], st.extWord[EMR_RTT_LO_BIT]}; // [RULE21] [RULE24]
  assign termOn         = st.termOn;
  assign outEnables     = st.oe;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstLocalN);

  chk_test_no_store: assert property ( // [RULE1]
    modeLoad && cmd.addr[MR_TEST_BIT] |=> testMode &&
      (st.modeWord[5:0] == $past(st.modeWord[5:0])) &&
      (st.modeWord[13:8] == $past(st.modeWord[13:8])))
    else $error("test mode load changed other mode fields");
  chk_dll_self_clear: assert property ( // [RULE2]
    modeLoad && !cmd.addr[MR_TEST_BIT] && cmd.addr[MR_DLL_RST_BIT]
      |=> dllResetPulse && !st.modeWord[MR_DLL_RST_BIT] ##1 !dllResetPulse)
    else $error("dll reset request not pulsed or not self-cleared");
  chk_read_cl3: assert property ( // [RULE11]
    isRead && readLat == 4'h3 |-> ##3 readFirstData)
    else $error("first read data not at latency 3");
  chk_read_cl5: assert property ( // [RULE25]
    isRead && readLat == 4'h5 |-> !st.rdPipe[0] ##5 readFirstData)
    else $error("first read data not at latency 5");
  chk_wr_ap_delay: assert property ( // [RULE4]
    isWrite && cmd.addr[AP_ADDR_BIT] && apTotal == 5'h07 |-> ##7 prechargePulse)
    else $error("auto precharge not issued after write recovery");
  chk_fast_exit_run: assert property ( // [RULE6]
    st.powerDown && st.activePd && !st.modeWord[MR_PD_BIT] |-> !dllFrozen)
    else $error("dll frozen in fast-exit active power-down");
  chk_slow_exit_freeze: assert property ( // [RULE7]
    $rose(st.powerDown) && st.activePd && st.modeWord[MR_PD_BIT] |-> dllFrozen)
    else $error("dll not frozen in slow-exit active power-down");
  chk_precharge_pd: assert property ( // [RULE8]
    st.powerDown && !st.activePd |-> !dllFrozen)
    else $error("exit select acted on precharge power-down");
  chk_self_refresh_dll: assert property ( // [RULE15]
    $fell(st.selfRefresh) |-> dllResetPulse && dllEnable == !st.extWord[EMR_DLL_DIS_BIT]
      && !readReady)
    else $error("dll not restarted on self refresh exit");
  chk_odt_hold: assert property ( // [RULE23]
    extLoad && newRtt != RTT_OFF |=> !termOn [*8])
    else $error("termination on within eight clocks of enabling load");
  chk_out_disable: assert property ( // [RULE20]
    st.extWord[EMR_OUT_DIS] |-> outEnables == '0)
    else $error("output driven while outputs disabled");
  chk_rdqsn_gate: assert property ( // [RULE18]
    outEnables.rdqsnOe |-> outEnables.rdqsOe && outEnables.dqsnOe)
    else $error("complement strobe copy without both strobes");

  cov_read: cover property (isRead ##[3:13] readFirstData);
  cov_write_ap: cover property (isWrite && cmd.addr[AP_ADDR_BIT] ##[6:24] prechargePulse);
  cov_self_refresh: cover property ($rose(st.selfRefresh) ##[1:50] $fell(st.selfRefresh));
  cov_term_on: cover property ($rose(termOn));
endmodule // dmr_mode_decode

// *** dmr_pkg.sv ***
// constants, field layout and carrier types for the mode-word decode block
// assumes one clock domain and a controller that keeps to the load timing
// How it works
// [RULE1] test-mode bit set on a mode load stores nothing else and enters test mode
// [RULE2] DLL reset request starts a DLL reset and reads back as zero
// [RULE3] controller waits 200 clocks after any DLL reset before a READ
// [RULE4] write with auto precharge delays internal precharge by write recovery clocks
// [RULE5] controller programs write recovery as 2 to 8, never reserved codes
// [RULE6] exit select 0 gives fast-exit active power-down, DLL keeps running
// [RULE7] exit select 1 gives slow-exit active power-down, DLL frozen
// [RULE8] exit select never affects precharge power-down
// [RULE9] CAS latency field selects 3 to 7 clocks; reserved codes avoided
// [RULE10] every read latency is a whole number of clocks
// [RULE11] with additive latency zero, first read data arrives m clocks after READ
// [RULE12] extended word holds its value until reloaded; array untouched
// [RULE13] controller loads the extended word only with banks idle
// [RULE14] DLL disable bit gates the DLL; each enable must be followed by reset
// [RULE15] self refresh turns the DLL off, exit re-enables and resets it
// [RULE16] controller adds precharge-all after refresh when DLL off below 25 MHz
// [RULE17] drive select 0 is full strength, 1 is reduced strength
// [RULE18] complement disable turns off DQS# and RDQS#; RDQS# needs RDQS and DQS#
// [RULE19] read strobe enable on x8 makes RDQS copy DQS during reads only
// [RULE20] output disable turns off every data and strobe output
// [RULE21] termination bits select 50, 75 or 150 ohms on data, strobe, mask pins
// [RULE22] with termination enabled the ODT pin switches it, not in self refresh
// [RULE23] controller keeps ODT low for eight clocks after a load enabling termination
// [RULE24] termination code 00 off, 01 75 ohms, 10 150 ohms, 11 50 ohms
// [RULE25] additive latency 0 to 6; read latency AL plus CL; write latency one less
package dmr_pkg;
  localparam int          WORD_W          = 14;
  localparam int          DATA_W          = 16;
  // register port offsets
  localparam logic [1:0]  OFS_MODE        = 2'h0;
  localparam logic [1:0]  OFS_EXT         = 2'h1;
  localparam logic [1:0]  OFS_STATUS      = 2'h2;
  localparam logic [1:0]  OFS_CTRL        = 2'h3;
  localparam int          CTRL_X8_BIT     = 0;
  localparam int          CTRL_CLR_BIT    = 1;
  // bank codes of the load command
  localparam logic [1:0]  BA_MODE         = 2'h0;
  localparam logic [1:0]  BA_EXT          = 2'h1;
  // mode word fields
  localparam int          MR_BL_LSB       = 0;
  localparam int          MR_CL_LSB       = 4;
  localparam int          MR_TEST_BIT     = 7;
  localparam int          MR_DLL_RST_BIT  = 8;
  localparam int          MR_WR_LSB       = 9;
  localparam int          MR_PD_BIT       = 12;
  localparam int          AP_ADDR_BIT     = 10;
  // extended word fields
  localparam int          EMR_DLL_DIS_BIT = 0;
  localparam int          EMR_DRIVE_BIT   = 1;
  localparam int          EMR_RTT_LO_BIT  = 2;
  localparam int          EMR_AL_LSB      = 3;
  localparam int          EMR_RTT_HI_BIT  = 6;
  localparam int          EMR_DQSN_DIS    = 10;
  localparam int          EMR_RDQS_EN     = 11;
  localparam int          EMR_OUT_DIS     = 12;
  localparam logic [13:0] MODE_RESET      = 14'h0000;
  localparam logic [13:0] EXT_RESET       = 14'h0000;
  // field codes
  localparam logic [2:0]  BL8_CODE        = 3'h3;
  localparam logic [2:0]  BL4_CLOCKS      = 3'h2;
  localparam logic [2:0]  BL8_CLOCKS      = 3'h4;
  localparam logic [2:0]  CL_MIN          = 3'h3;
  localparam logic [2:0]  AL_MAX          = 3'h6;
  localparam logic [3:0]  WR_MIN          = 4'h2;
  localparam logic [1:0]  RTT_OFF         = 2'h0;
  localparam logic [1:0]  RTT_75          = 2'h1;
  localparam logic [1:0]  RTT_150         = 2'h2;
  localparam logic [1:0]  RTT_50          = 2'h3;
  // timing counts in clocks
  localparam logic [7:0]  DLL_LOCK_CYCLES = 8'hC8;
  localparam logic [3:0]  ODT_HOLD_CYCLES = 4'h8;
  localparam int          FAST_EXIT_DEF   = 2;
  localparam int          SLOW_EXIT_DEF   = 7;
  // error flag positions
  localparam int          ERR_ODT_EARLY   = 0;
  localparam int          ERR_RESERVED    = 1;
  localparam int          ERR_READ_EARLY  = 2;

  typedef struct packed {
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic [2:0]  ba;
    logic [13:0] addr;
  } dmr_cmd_t;

  typedef struct packed {
    logic dqOe;
    logic dqsOe;
    logic dqsnOe;
    logic rdqsOe;
    logic rdqsnOe;
  } dmr_oe_t;

  typedef struct packed {
    logic [13:0] modeWord;
    logic [13:0] extWord;
    logic        x8Config;
    logic        testMode;
    logic        dllResetPulse;
    logic [7:0]  dllLockCnt;
    logic        dllNeedsReset;
    logic [15:0] rdPipe;
    logic [2:0]  burstCnt;
    logic [4:0]  apCnt;
    logic [2:0]  apBank;
    logic        precPulse;
    logic [2:0]  precBank;
    logic [7:0]  bankOpen;
    logic        selfRefresh;
    logic        powerDown;
    logic        activePd;
    logic [3:0]  exitCnt;
    logic [3:0]  odtHoldCnt;
    logic        termOn;
    logic [2:0]  errors;
    dmr_oe_t     oe;
    logic        dllEnable;
    logic        dllFrozen;
    logic        readReady;
    logic [15:0] rdata;
  } dmr_state_t;
endpackage

// *** dmr_ctrl_model.sv ***
// command-pin model of the memory controller facing the decode block
// assumes one caller at a time; every task starts on a rising edge
`timescale 1ns/100ps
module dmr_ctrl_model
  import dmr_pkg::*;
(
  // clock
  input  wire logic mclk,
  // device pins
  output dmr_cmd_t  cmd,
  output logic      cke,
  output logic      odt
);
  int lockLeft = 0;
  int odtLeft  = 0;
  initial begin
    cmd = {4'hF, 3'h0, 14'h0000};
    cke = 1'b1;
    odt = 1'b0;
  end
  always @(posedge mclk) begin
    if (lockLeft > 0) lockLeft <= lockLeft - 1;
    if (odtLeft > 0) odtLeft <= odtLeft - 1;
  end
  // deselect flips the address so a stale value never looks like a command
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a,
                       input logic ck);
    dmr_cmd_t c;
    c = {1'b0, rcw, ba, a};
    @(posedge mclk);
    cmd <= c;
    cke <= ck;
    @(posedge mclk);
    c = ~c;
    c.csN = 1'b1;
    cmd <= c;
  endtask
  task automatic load(input logic [1:0] ba, input logic [13:0] w);
    issue(3'h2, 3'h0, 14'h0400, 1'b1);
    issue(3'h0, {1'b0, ba}, w, 1'b1);
    if (ba == BA_MODE && w[MR_DLL_RST_BIT]) lockLeft = 201;
    if (ba == BA_EXT && (w[EMR_RTT_HI_BIT] | w[EMR_RTT_LO_BIT])) odtLeft = 9;
  endtask
  task automatic read(input logic [2:0] ba, input logic [13:0] a);
    while (lockLeft > 0) @(posedge mclk);
    issue(3'h5, ba, a, 1'b1);
  endtask
  task automatic wake(input logic fromSelfRefresh);
    issue(3'h7, 3'h0, 14'h0000, 1'b1);
    if (fromSelfRefresh) lockLeft = 201;
  endtask
  // auto refresh; with the DLL off a precharge-all follows, safe at any clock rate
  task automatic refresh(input logic dllOff);
    issue(3'h1, 3'h0, 14'h0000, 1'b1);
    if (dllOff) issue(3'h2, 3'h0, 14'h0400, 1'b1);
  endtask
  task automatic setOdt(input logic v);
    while (v && odtLeft > 0) @(posedge mclk);
    @(posedge mclk);
    odt <= v;
  endtask
endmodule // dmr_ctrl_model

// *** ddr2_mode_register_decode_tb.sv ***
// self-checking bench for the mode-word decode block
// assumes the controller model drives the command pins and the bench the register port
`timescale 1ns/100ps
module ddr2_mode_register_decode_tb;
  import dmr_pkg::*;
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] WRC = 3'h4;
  logic        mclk;
  logic        rst_n;
  logic [1:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  dmr_cmd_t    cmd;
  logic        cke, odt, dllEnable, dllResetPulse, dllFrozen, readReady, testMode;
  logic        readFirstData, prechargePulse, driveReduced, termOn;
  logic [2:0]  prechargeBank;
  logic [1:0]  rttCode;
  dmr_oe_t     outEnables;
  int          failCount = 0;
  int          nTests = 0;
  int          k, kPd[2];
  always #2.5 mclk = ~mclk;
  dmr_ctrl_model ctl_u (.mclk, .cmd, .cke, .odt);
  dmr_mode_decode dut_u (
    .mclk, .rst_n, .cmd, .cke, .odt, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .dllEnable, .dllResetPulse, .dllFrozen, .readReady, .testMode, .readFirstData,
    .prechargePulse, .prechargeBank, .driveReduced, .rttCode, .termOn, .outEnables);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask
  // counts falling edges after a command until the chosen output shows high
  task automatic waitSig(input int sel, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      s = (sel == 0) ? readFirstData : (sel == 1) ? prechargePulse : readReady;
    end while (s !== 1'b1 && n < 400);
  endtask
  // burst of four; write recovery coded as clocks minus one
  function automatic logic [13:0] mw(input int cl, input int wr, input logic pd, input logic dr);
    return {1'b0, pd, 3'(wr - 1), dr, 1'b0, 3'(cl), 1'b0, 3'h2};
  endfunction
  task automatic doRead(input logic [13:0] ext, input int cl, input int al, input dmr_oe_t oe);
    ctl_u.load(BA_EXT, ext | 14'(al << EMR_AL_LSB));
    ctl_u.load(BA_MODE, mw(cl, 2, 1'b0, 1'b0));
    ctl_u.issue(ACT, 3'h1, 14'h0010, 1'b1);
    ctl_u.read(3'h1, 14'h0000);
    waitSig(0, k);
    chk(16'(k), 16'(al + cl), "read latency");
    chk(16'(outEnables), 16'(oe), "output enables");
  endtask
  task automatic testRegs();
    logic [15:0] d;
    rd(OFS_MODE, d);
    chk(d, 16'h0000, "mode reset");
    rd(OFS_STATUS, d);
    chk(d, 16'h0082, "status reset");
    ctl_u.load(BA_MODE, mw(3, 2, 1'b0, 1'b1));
    // the reset pulse stands only in the cycle after the load
    @(negedge mclk);
    chk(16'({dllResetPulse, readReady}), 16'h0002, "dll reset start");
    waitSig(2, k);
    chk(16'(k), 16'd200, "dll lock");
    rd(OFS_MODE, d);
    chk(d, 16'(mw(3, 2, 1'b0, 1'b0)), "self clear");
    ctl_u.load(BA_MODE, mw(2, 2, 1'b0, 1'b0));
    rd(OFS_STATUS, d);
    chk(d & 16'h0E00, 16'h0400, "reserved code flag");
    $display("test registers done");
  endtask
  task automatic testReads();
    logic [15:0] d;
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= OFS_CTRL;
    regWdata <= 16'h0003;
    @(posedge mclk);
    regWr <= 1'b0;
    rd(OFS_STATUS, d);
    chk(d & 16'h0E00, 16'h0000, "error clear");
    for (int al = 0; al <= 2; al += 2)
      for (int cl = 3; cl <= 7; cl++)
        doRead(14'h0800, cl, al, 5'h1F);
    doRead(14'h0000, 4, 0, 5'h1C);
    doRead(14'h0C00, 3, 6, 5'h1A);
    doRead(14'h1800, 3, 0, 5'h00);
    $display("test reads done");
  endtask
  task automatic testWrites();
    for (int wr = 2; wr <= 8; wr++) begin
      ctl_u.load(BA_EXT, 14'h0000);
      ctl_u.load(BA_MODE, mw(3, wr, 1'b0, 1'b0));
      ctl_u.issue(ACT, 3'h5, 14'h0020, 1'b1);
      ctl_u.issue(WRC, 3'h5, 14'h0400, 1'b1);
      waitSig(1, k);
      chk(16'(k), 16'(4 + wr), "auto precharge delay");
      chk(16'(prechargeBank), 16'h0005, "precharge bank");
    end
    ctl_u.load(BA_MODE, 14'h00F2);
    @(negedge mclk);
    chk(16'(testMode), 16'h0001, "test mode on");
    ctl_u.load(BA_MODE, mw(3, 2, 1'b0, 1'b0));
    @(negedge mclk);
    chk(16'(testMode), 16'h0000, "test mode off");
    $display("test writes done");
  endtask
  task automatic testExt();
    for (int i = 0; i < 4; i++) begin
      ctl_u.load(BA_EXT, 14'((i / 2) * 16'h0041 + (i % 2) * 16'h0006));
      repeat (2) @(negedge mclk);
      chk(16'(rttCode), 16'(i), "termination code");
      chk(16'({driveReduced, dllEnable}), 16'(i % 2 * 2 + 1 - i / 2), "ext");
      ctl_u.setOdt(1'b1);
      repeat (3) @(negedge mclk);
      chk(16'(termOn), 16'(i != 0), "termination");
      ctl_u.setOdt(1'b0);
    end
    ctl_u.refresh(1'b1);
    ctl_u.load(BA_EXT, 14'h0000);
    ctl_u.load(BA_MODE, mw(3, 2, 1'b1, 1'b1));
    waitSig(2, k);
    for (int pd = 0; pd < 2; pd++) begin
      ctl_u.load(BA_MODE, mw(3, 2, pd[0], 1'b0));
      ctl_u.issue(ACT, 3'h2, 14'h0030, 1'b1);
      ctl_u.issue(3'h7, 3'h0, 14'h0000, 1'b0);
      repeat (3) @(negedge mclk);
      chk(16'(dllFrozen), 16'(pd), "active power-down");
      ctl_u.wake(1'b0);
      waitSig(2, kPd[pd]);
    end
    chk(16'(kPd[1] - kPd[0]), 16'(SLOW_EXIT_DEF - FAST_EXIT_DEF), "exit gap");
    ctl_u.load(BA_MODE, mw(3, 2, 1'b1, 1'b0));
    ctl_u.issue(3'h7, 3'h0, 14'h0000, 1'b0);
    repeat (3) @(negedge mclk);
    chk(16'(dllFrozen), 16'h0000, "precharge power-down");
    ctl_u.wake(1'b0);
    $display("test extended word done");
  endtask
  task automatic testSelfRefresh();
    logic seen;
    seen = 1'b0;
    ctl_u.issue(3'h1, 3'h0, 14'h0000, 1'b0);
    repeat (3) @(negedge mclk);
    chk(16'(dllEnable), 16'h0000, "dll off in self refresh");
    ctl_u.wake(1'b1);
    repeat (4) @(negedge mclk) seen |= dllResetPulse;
    chk(16'({seen, dllEnable, readReady}), 16'h0006, "self refresh exit");
    $display("test self refresh done");
  endtask
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    regAddr = 2'h0;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    testRegs();
    testReads();
    testWrites();
    testExt();
    testSelfRefresh();
    conclude();
  end
  initial begin
    #200000;
    failCount++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // ddr2_mode_register_decode_tb
